//--- hdl/pcum_pin_cell.sv
// One pin: two ranked overrides, latch, direction and input synchroniser
`default_nettype none
module pcum_pin_cell
  import pcum_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic dirBit,
  input  wire logic latchBit,
  input  wire logic firstEn,
  input  wire logic firstVal,
  input  wire logic secondEn,
  input  wire logic secondVal,
  input  wire logic padIn,
  output logic      padOut,
  output logic      padOe,
  output logic      level
);
  logic syncA_r;
  logic level_r;

  // Driver enabled only with direction bit cleared
  assign padOe = (dirBit == DIR_OUT);

  // Higher ranked override first, then second, then latch
  always_comb
  begin
    if (firstEn)
      padOut = firstVal;
    else if (secondEn)
      padOut = secondVal;
    else
      padOut = latchBit;
  end

  // Two-stage synchroniser standing in for the input buffer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      syncA_r <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      syncA_r <= padIn;
      level_r <= syncA_r;
    end
  end

  assign level = level_r;
endmodule : pcum_pin_cell
`default_nettype wire

//--- hdl/pcum_pkg.sv
// Constants for the upper port pin multiplexer
`default_nettype none
package pcum_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;
  // Register indices
  localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_OUT_LATCH = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_INT_MAIN  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_INT_EDGES = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_INT_EXT   = 4'h5;
  // Reset values
  localparam logic [DATA_W-1:0] RST_LATCH     = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIRECTION = 8'hFF;
  localparam logic [DATA_W-1:0] RST_INT       = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE    = 8'h00;
  // Implemented bits of the interrupt control registers
  localparam logic [DATA_W-1:0] MASK_INT_MAIN  = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_INT_EDGES = 8'hF5;
  localparam logic [DATA_W-1:0] MASK_INT_EXT   = 8'hDB;
  // Field positions
  localparam int unsigned BIT_PIN_FIVE   = 5;
  localparam int unsigned BIT_PIN_SIX    = 6;
  localparam int unsigned BIT_PIN_SEVEN  = 7;
  localparam int unsigned BIT_EDGE_TWO   = 4;
  localparam int unsigned BIT_FLAG_TWO   = 1;
  localparam int unsigned LOW_PINS       = 5;
  localparam int unsigned UPPER_PINS     = 3;
  // Direction bit values
  localparam logic DIR_OUT = 1'b0;
  localparam logic DIR_IN  = 1'b1;
endpackage : pcum_pkg
`default_nettype wire

//--- hdl/port_c_upper_pin_mux.sv
// Upper port pins five to seven: registers, peripheral overrides, relocation
// Notes on behaviour
// - Output pin with no override drives its output latch bit.
// - Input pin level is sampled and read back in pin level register.
// - SPI master clock drives pin five when output; input feeds external clock.
// - I2C clock drives pin five over latch; input path per serial unit setting.
// - Async transmit data drives pin six over latch; software sets output.
// - Sync mode clock drives pin six when output; input passes external clock.
// - Pin six as input supplies SPI slave select.
// - Pin seven as input supplies async receive data.
// - Sync data drives pin seven when output; reception needs input direction.
// - SPI data out drives pin seven over latch when output.
// - Serial and timer clock functions relocate to alternate neighbour pins.
// - Unimplemented interrupt control bits read as zero.
// - Direction register reads stored contents regardless of overrides.
// - After reset every pin is a digital input.
`default_nettype none
module port_c_upper_pin_mux
  import pcum_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [DATA_W-1:0] regRdata,
  // Register contents towards the rest of the chip
  output logic      [DATA_W-1:0] outputLatchReg,
  output logic      [DATA_W-1:0] directionReg,
  output logic      [DATA_W-1:0] intMainReg,
  output logic      [DATA_W-1:0] intEdgesReg,
  output logic      [DATA_W-1:0] intExtReg,
  input  wire logic [LOW_PINS-1:0] lowPinLevels,
  // Synchronous serial unit
  input  wire logic              sspSpiMaster,
  input  wire logic              sspI2cMode,
  input  wire logic              sspSckOut,
  input  wire logic              sspSclOut,
  input  wire logic              sspSdoEn,
  input  wire logic              sspSdoOut,
  input  wire logic              sspAltPins,
  input  wire logic              timerAltClk,
  output logic                   sspSckIn,
  output logic                   sspSsIn,
  output logic                   sspSdiIn,
  output logic                   timerExtClkIn,
  // Enhanced serial unit
  input  wire logic              euTxEn,
  input  wire logic              euTxOut,
  input  wire logic              euSyncMode,
  input  wire logic              euSyncClkOut,
  input  wire logic              euSyncDataOut,
  output logic                   euRxIn,
  output logic                   euClkIn,
  output logic                   euDataIn,
  output logic                   externalIrqTwo,
  // Pins five to seven
  input  wire logic              pinFiveIn,
  output logic                   pinFiveOut,
  output logic                   pinFiveOe,
  input  wire logic              pinSixIn,
  output logic                   pinSixOut,
  output logic                   pinSixOe,
  input  wire logic              pinSevenIn,
  output logic                   pinSevenOut,
  output logic                   pinSevenOe,
  // Neighbouring port alternate pins and lower pin functions
  input  wire logic              pinFourLevel,
  input  wire logic              pinThreeLevel,
  input  wire logic              altPinZeroIn,
  input  wire logic              altPinTwoIn,
  input  wire logic              altPinThreeIn,
  output logic                   altPinOneEn,
  output logic                   altPinOneOut,
  output logic                   altPinTwoEn,
  output logic                   altPinTwoOut,
  output logic                   altPinThreeEn,
  output logic                   altPinThreeOut
);
  logic [DATA_W-1:0] latch_r;
  logic [DATA_W-1:0] dir_r;
  logic [DATA_W-1:0] intMain_r;
  logic [DATA_W-1:0] intEdges_r;
  logic [DATA_W-1:0] intExt_r;
  logic [DATA_W-1:0] intExt_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] pinLevels;
  logic              levelFive;
  logic              levelSix;
  logic              levelSeven;
  logic              altZero_r;
  logic              altZeroS_r;
  logic              altTwo_r;
  logic              altTwoS_r;
  logic              altThree_r;
  logic              altThreeS_r;
  logic              fivePrev_r;
  logic              int2Edge;
  logic              fiveSckEn;
  logic              fiveSclEn;
  logic              sixClkEn;
  logic              sixTxEn;
  logic              sevenDtEn;
  logic              sevenSdoEn;
  logic              wrPinLevel;
  logic              wrLatch;

  assign wrPinLevel = regWrite && (regAddr == ADDR_PIN_LEVEL);
  assign wrLatch    = regWrite && (regAddr == ADDR_OUT_LATCH);

  // latch written directly or via pin level register
  always_ff @(posedge mclk)
  begin
    if (rst)
      latch_r <= RST_LATCH;
    else if (wrPinLevel || wrLatch)
      latch_r <= regWdata;
  end

  // all direction bits set at reset
  always_ff @(posedge mclk)
  begin
    if (rst)
      dir_r <= RST_DIRECTION;
    else if (regWrite && (regAddr == ADDR_DIRECTION))
      dir_r <= regWdata;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      intMain_r  <= RST_INT;
      intEdges_r <= RST_INT;
    end
    else
    begin
      if (regWrite && (regAddr == ADDR_INT_MAIN))
        intMain_r <= regWdata & MASK_INT_MAIN;
      if (regWrite && (regAddr == ADDR_INT_EDGES))
        intEdges_r <= regWdata & MASK_INT_EDGES;
    end
  end

  // Edge on pin five as input, polarity chosen by edge select bit
  always_ff @(posedge mclk)
  begin
    if (rst)
      fivePrev_r <= 1'b0;
    else
      fivePrev_r <= levelFive;
  end

  assign int2Edge = (dir_r[BIT_PIN_FIVE] == DIR_IN) &&
                    (intEdges_r[BIT_EDGE_TWO] ? (levelFive && !fivePrev_r)
                                              : (!levelFive && fivePrev_r));

  // Flag set by the pin edge wins over a software write
  always_comb
  begin
    intExt_nxt = intExt_r;
    if (regWrite && (regAddr == ADDR_INT_EXT))
      intExt_nxt = regWdata & MASK_INT_EXT;
    if (int2Edge)
      intExt_nxt[BIT_FLAG_TWO] = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      intExt_r <= RST_INT;
    else
      intExt_r <= intExt_nxt;
  end

  // sampled levels of upper pins beside lower pin levels
  assign pinLevels = {levelSeven, levelSix, levelFive, lowPinLevels};

  // Read data valid only in the cycle after the read strobe
  always_comb
  begin
    rdata_nxt = RDATA_IDLE;
    if (regRead)
    begin
      case (regAddr)
        ADDR_PIN_LEVEL: rdata_nxt = pinLevels;
        ADDR_OUT_LATCH: rdata_nxt = latch_r;
        ADDR_DIRECTION: rdata_nxt = dir_r;
        ADDR_INT_MAIN:  rdata_nxt = intMain_r;
        ADDR_INT_EDGES: rdata_nxt = intEdges_r;
        ADDR_INT_EXT:   rdata_nxt = intExt_r;
        default:        rdata_nxt = RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_r <= RDATA_IDLE;
    else
      rdata_r <= rdata_nxt;
  end

  assign regRdata       = rdata_r;
  assign outputLatchReg = latch_r;
  assign directionReg   = dir_r;
  assign intMainReg     = intMain_r;
  assign intEdgesReg    = intEdges_r;
  assign intExtReg      = intExt_r;

  // relocated serial functions leave the upper pins
  assign fiveSclEn  = sspI2cMode && !sspAltPins;
  assign fiveSckEn  = sspSpiMaster && !sspI2cMode && !sspAltPins;
  assign sevenSdoEn = sspSdoEn && !sspAltPins;
  assign sixClkEn   = euSyncMode;
  assign sixTxEn    = euTxEn && !euSyncMode;
  assign sevenDtEn  = euSyncMode;

  // I2C clock ranks above SPI clock
  pcum_pin_cell u_pinFive (
    .mclk      (mclk),
    .rst       (rst),
    .dirBit    (dir_r[BIT_PIN_FIVE]),
    .latchBit  (latch_r[BIT_PIN_FIVE]),
    .firstEn   (fiveSclEn),
    .firstVal  (sspSclOut),
    .secondEn  (fiveSckEn),
    .secondVal (sspSckOut),
    .padIn     (pinFiveIn),
    .padOut    (pinFiveOut),
    .padOe     (pinFiveOe),
    .level     (levelFive)
  );

  // sync clock ranks above transmit data
  pcum_pin_cell u_pinSix (
    .mclk      (mclk),
    .rst       (rst),
    .dirBit    (dir_r[BIT_PIN_SIX]),
    .latchBit  (latch_r[BIT_PIN_SIX]),
    .firstEn   (sixClkEn),
    .firstVal  (euSyncClkOut),
    .secondEn  (sixTxEn),
    .secondVal (euTxOut),
    .padIn     (pinSixIn),
    .padOut    (pinSixOut),
    .padOe     (pinSixOe),
    .level     (levelSix)
  );

  // sync data ranks above SPI data out
  pcum_pin_cell u_pinSeven (
    .mclk      (mclk),
    .rst       (rst),
    .dirBit    (dir_r[BIT_PIN_SEVEN]),
    .latchBit  (latch_r[BIT_PIN_SEVEN]),
    .firstEn   (sevenDtEn),
    .firstVal  (euSyncDataOut),
    .secondEn  (sevenSdoEn),
    .secondVal (sspSdoOut),
    .padIn     (pinSevenIn),
    .padOut    (pinSevenOut),
    .padOe     (pinSevenOe),
    .level     (levelSeven)
  );

  // Alternate neighbour pins are asynchronous: two stages each
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      altZero_r   <= 1'b0;
      altZeroS_r  <= 1'b0;
      altTwo_r    <= 1'b0;
      altTwoS_r   <= 1'b0;
      altThree_r  <= 1'b0;
      altThreeS_r <= 1'b0;
    end
    else
    begin
      altZero_r   <= altPinZeroIn;
      altZeroS_r  <= altZero_r;
      altTwo_r    <= altPinTwoIn;
      altTwoS_r   <= altTwo_r;
      altThree_r  <= altPinThreeIn;
      altThreeS_r <= altThree_r;
    end
  end

  // override requests toward the alternate pins
  assign altPinOneEn    = sspSdoEn && sspAltPins;
  assign altPinOneOut   = sspSdoOut;
  assign altPinTwoEn    = sspI2cMode && sspAltPins;
  assign altPinTwoOut   = 1'b0;
  assign altPinThreeEn  = (sspI2cMode || sspSpiMaster) && sspAltPins;
  assign altPinThreeOut = sspI2cMode ? sspSclOut : sspSckOut;

  // external serial clock from pin five or its alternate
  assign sspSckIn = sspAltPins ? altThreeS_r : levelFive;
  // data in and timer clock from selected pin
  assign sspSdiIn      = sspAltPins ? altTwoS_r : pinFourLevel;
  assign timerExtClkIn = timerAltClk ? altZeroS_r : pinThreeLevel;

  // slave select from pin six level
  assign sspSsIn = levelSix;
  // receive data from pin seven level
  assign euRxIn = levelSeven;
  // sync data input from pin seven level
  assign euDataIn = levelSeven;
  // external sync clock from pin six level
  assign euClkIn = levelSix;
  assign externalIrqTwo = levelFive;
endmodule : port_c_upper_pin_mux
`default_nettype wire

//--- test/pcum_board_model.sv
// Board side of pins five to seven, pulled up when nobody drives
`default_nettype none
module pcum_board_model (
  input  wire logic       pinFiveOut,
  input  wire logic       pinFiveOe,
  input  wire logic       pinSixOut,
  input  wire logic       pinSixOe,
  input  wire logic       pinSevenOut,
  input  wire logic       pinSevenOe,
  input  wire logic [2:0] extDrive,
  input  wire logic [2:0] extLevel,
  output logic            pinFiveIn,
  output logic            pinSixIn,
  output logic            pinSevenIn
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pinFiveIn  = pinFiveOe ? pinFiveOut : (extDrive[0] ? extLevel[0] : 1'b1);
  assign pinSixIn   = pinSixOe ? pinSixOut : (extDrive[1] ? extLevel[1] : 1'b1);
  assign pinSevenIn = pinSevenOe ? pinSevenOut : (extDrive[2] ? extLevel[2] : 1'b1);
endmodule : pcum_board_model
`default_nettype wire

//--- test/pcum_mux_asserts.sv
// Port-level checks for the upper pin multiplexer
`default_nettype none
module pcum_mux_asserts
  import pcum_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regRead,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic [DATA_W-1:0] directionReg,
  input wire logic [DATA_W-1:0] outputLatchReg,
  input wire logic [DATA_W-1:0] intEdgesReg,
  input wire logic [DATA_W-1:0] intExtReg,
  input wire logic              sspI2cMode,
  input wire logic              sspSpiMaster,
  input wire logic              sspSckOut,
  input wire logic              sspSclOut,
  input wire logic              sspAltPins,
  input wire logic              euSyncMode,
  input wire logic              euSyncClkOut,
  input wire logic              euTxEn,
  input wire logic              euTxOut,
  input wire logic              pinFiveOut,
  input wire logic              pinFiveOe,
  input wire logic              pinSixOut,
  input wire logic              pinSixOe,
  input wire logic              pinSevenOe,
  input wire logic              pinSevenIn,
  input wire logic              euRxIn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_read_dir;
    regRead && regAddr == ADDR_DIRECTION;
  endsequence
  a_oe_from_dir: assert property (
    {pinSevenOe, pinSixOe, pinFiveOe} == ~directionReg[7:5]) else $error("oe vs direction");
  a_reset_inputs: assert property (
    $past(rst) |-> directionReg == 8'hFF && !pinFiveOe) else $error("not input after reset");
  a_read_dir: assert property (
    s_read_dir |=> regRdata == $past(directionReg)) else $error("direction readback");
  a_rdata_idle: assert property (
    !regRead |=> regRdata == RDATA_IDLE) else $error("read data not idle");
  a_pin_five_drive: assert property (
    pinFiveOut == ((sspI2cMode && !sspAltPins) ? sspSclOut :
      ((sspSpiMaster && !sspAltPins) ? sspSckOut : outputLatchReg[5])))
    else $error("pin five source");
  a_pin_six_drive: assert property (
    pinSixOut == (euSyncMode ? euSyncClkOut : (euTxEn ? euTxOut : outputLatchReg[6])))
    else $error("pin six source");
  a_rx_sync_lag: assert property (
    !$past(rst) && !$past(rst, 2) |-> euRxIn == $past(pinSevenIn, 2))
    else $error("receive path lag");
  a_unimpl_zero: assert property (
    (intExtReg & ~MASK_INT_EXT) == 8'h00 && (intEdgesReg & ~MASK_INT_EDGES) == 8'h00)
    else $error("unimplemented bit set");
endmodule : pcum_mux_asserts
bind port_c_upper_pin_mux pcum_mux_asserts u_chk (.mclk, .rst, .regAddr, .regRead,
  .regRdata, .directionReg, .outputLatchReg, .intEdgesReg, .intExtReg, .sspI2cMode,
  .sspSpiMaster, .sspSckOut, .sspSclOut, .sspAltPins, .euSyncMode, .euSyncClkOut,
  .euTxEn, .euTxOut, .pinFiveOut, .pinFiveOe, .pinSixOut, .pinSixOe, .pinSevenOe,
  .pinSevenIn, .euRxIn);
`default_nettype wire

//--- test/port_c_upper_pin_mux_tb_top.sv
// Self-checking bench for the upper pin multiplexer
`default_nettype none
module port_c_upper_pin_mux_tb_top
  import pcum_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0]   regAddr;
  logic [DATA_W-1:0]   regWdata, regRdata, outputLatchReg, directionReg;
  logic [DATA_W-1:0]   intMainReg, intEdgesReg, intExtReg;
  logic [LOW_PINS-1:0] lowPinLevels;
  logic [2:0]          extDrive, extLevel;
  logic mclk, rst, regWrite, regRead, sspSpiMaster, sspI2cMode, sspSckOut, sspSclOut;
  logic sspSdoEn, sspSdoOut, sspAltPins, timerAltClk, sspSckIn, sspSsIn, sspSdiIn;
  logic timerExtClkIn, euTxEn, euTxOut, euSyncMode, euSyncClkOut, euSyncDataOut;
  logic euRxIn, euClkIn, euDataIn, externalIrqTwo, pinFiveIn, pinFiveOut, pinFiveOe;
  logic pinSixIn, pinSixOut, pinSixOe, pinSevenIn, pinSevenOut, pinSevenOe;
  logic pinFourLevel, pinThreeLevel, altPinZeroIn, altPinTwoIn, altPinThreeIn;
  logic altPinOneEn, altPinOneOut, altPinTwoEn, altPinTwoOut, altPinThreeEn, altPinThreeOut;
  int   n_mismatch, total_checks;
  port_c_upper_pin_mux u_dut (.mclk, .rst, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .outputLatchReg, .directionReg, .intMainReg, .intEdgesReg, .intExtReg,
    .lowPinLevels, .sspSpiMaster, .sspI2cMode, .sspSckOut, .sspSclOut, .sspSdoEn,
    .sspSdoOut, .sspAltPins, .timerAltClk, .sspSckIn, .sspSsIn, .sspSdiIn, .timerExtClkIn,
    .euTxEn, .euTxOut, .euSyncMode, .euSyncClkOut, .euSyncDataOut, .euRxIn, .euClkIn,
    .euDataIn, .externalIrqTwo, .pinFiveIn, .pinFiveOut, .pinFiveOe, .pinSixIn, .pinSixOut,
    .pinSixOe, .pinSevenIn, .pinSevenOut, .pinSevenOe, .pinFourLevel, .pinThreeLevel,
    .altPinZeroIn, .altPinTwoIn, .altPinThreeIn, .altPinOneEn, .altPinOneOut,
    .altPinTwoEn, .altPinTwoOut, .altPinThreeEn, .altPinThreeOut);
  pcum_board_model u_board (.pinFiveOut, .pinFiveOe, .pinSixOut, .pinSixOe, .pinSevenOut,
    .pinSevenOe, .extDrive, .extLevel, .pinFiveIn, .pinSixIn, .pinSevenIn);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [DATA_W-1:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string n);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 chk(n, e, regRdata);
  endtask : rd
  // Overrides enable {i2c, spi, sync, tx, sdo}; data {scl, sck, syncClk, tx, sdo}
  task automatic ov(input logic [4:0] en, dat, input logic [2:0] e);
    @(posedge mclk);
    {sspI2cMode, sspSpiMaster, euSyncMode, euTxEn, sspSdoEn} <= en;
    {sspSclOut, sspSckOut, euSyncClkOut, euTxOut, sspSdoOut} <= dat;
    euSyncDataOut <= dat[2];
    #1 chk("pin drive", 8'(e), 8'({pinSevenOut, pinSixOut, pinFiveOut}));
  endtask : ov
  task automatic t_reset();
    rd(ADDR_DIRECTION, RST_DIRECTION, "direction");
    rd(ADDR_OUT_LATCH, RST_LATCH, "latch");
    chk("oe", 8'h00, 8'({pinSevenOe, pinSixOe, pinFiveOe}));
  endtask : t_reset
  task automatic t_prio();
    wr(ADDR_OUT_LATCH, 8'h40);
    wr(ADDR_DIRECTION, 8'h1F);
    ov(5'h00, 5'h1F, 3'h2);
    chk("oe", 8'h07, 8'({pinSevenOe, pinSixOe, pinFiveOe}));
    ov(5'h08, 5'h08, 3'h3);
    ov(5'h18, 5'h08, 3'h2);
    ov(5'h10, 5'h10, 3'h3);
    ov(5'h02, 5'h00, 3'h0);
    ov(5'h06, 5'h04, 3'h6);
    ov(5'h01, 5'h01, 3'h6);
    ov(5'h05, 5'h01, 3'h0);
    rd(ADDR_DIRECTION, 8'h1F, "direction");
    ov(5'h00, 5'h00, 3'h2);
  endtask : t_prio
  task automatic t_inputs();
    logic [2:0] lv [2] = '{3'h5, 3'h2};
    wr(ADDR_DIRECTION, 8'hFF);
    foreach (lv[i])
    begin
      extLevel <= lv[i];
      repeat (3) @(posedge mclk);
      rd(ADDR_PIN_LEVEL, {lv[i], lowPinLevels}, "pin levels");
      chk("rx", 8'(lv[i][2]), 8'(euRxIn));
      chk("sync data", 8'(lv[i][2]), 8'(euDataIn));
      chk("slave select", 8'(lv[i][1]), 8'(sspSsIn));
      chk("sync clock", 8'(lv[i][1]), 8'(euClkIn));
      chk("spi clock", 8'(lv[i][0]), 8'(sspSckIn));
      chk("irq two", 8'(lv[i][0]), 8'(externalIrqTwo));
    end
  endtask : t_inputs
  task automatic t_reloc();
    logic [5:0] altOut;
    @(posedge mclk);
    {sspAltPins, timerAltClk, altPinThreeIn, altPinTwoIn, altPinZeroIn} <= 5'h1F;
    {pinFourLevel, pinThreeLevel} <= 2'h0;
    repeat (3) @(posedge mclk);
    #1 chk("alt ins", 8'h07, 8'({sspSckIn, sspSdiIn, timerExtClkIn}));
    wr(ADDR_OUT_LATCH, 8'h40);
    wr(ADDR_DIRECTION, 8'h1F);
    ov(5'h19, 5'h1B, 3'h2);
    altOut = {altPinOneEn, altPinOneOut, altPinTwoEn, altPinTwoOut,
              altPinThreeEn, altPinThreeOut};
    chk("alt outs", 8'h3B, 8'(altOut));
    ov(5'h00, 5'h00, 3'h2);
    @(posedge mclk);
    {sspAltPins, timerAltClk} <= 2'h0;
    #1 chk("home ins", 8'h00, 8'({sspSdiIn, timerExtClkIn}));
  endtask : t_reloc
  task automatic t_int();
    wr(ADDR_INT_EXT, 8'hFF);
    rd(ADDR_INT_EXT, MASK_INT_EXT, "int ext");
    wr(ADDR_INT_EDGES, 8'hFF);
    rd(ADDR_INT_EDGES, MASK_INT_EDGES, "int edges");
    wr(ADDR_INT_MAIN, 8'hFF);
    rd(ADDR_INT_MAIN, MASK_INT_MAIN, "int main");
    chk("int main port", MASK_INT_MAIN, intMainReg);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00, "unmapped");
    // Rising edge on pin five as input sets the second flag
    wr(ADDR_DIRECTION, RST_DIRECTION);
    wr(ADDR_INT_EXT, 8'h00);
    extLevel <= 3'h1;
    repeat (4) @(posedge mclk);
    rd(ADDR_INT_EXT, 8'h02, "int two flag");
    chk("int ext port", 8'h02, intExtReg);
    chk("irq two high", 8'h01, 8'(externalIrqTwo));
  endtask : t_int
  task automatic t_rerun();
    wr(ADDR_DIRECTION, 8'h1F);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_DIRECTION, RST_DIRECTION, "direction after reset");
    rd(ADDR_OUT_LATCH, RST_LATCH, "latch after reset");
    rd(ADDR_INT_EXT, RST_INT, "int ext after reset");
    chk("oe after reset", 8'h00, 8'({pinSevenOe, pinSixOe, pinFiveOe}));
  endtask : t_rerun
  initial
  begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    n_mismatch = 0;
    total_checks = 0;
    rst = 1'b1;
    regAddr = '0;
    regWdata = '0;
    lowPinLevels = 5'h0A;
    extDrive = 3'h7;
    extLevel = 3'h0;
    {regWrite, regRead, sspSpiMaster, sspI2cMode, sspSckOut, sspSclOut, sspSdoEn} = '0;
    {sspSdoOut, sspAltPins, timerAltClk, euTxEn, euTxOut, euSyncMode, euSyncClkOut} = '0;
    {euSyncDataOut, pinFourLevel, pinThreeLevel, altPinZeroIn, altPinTwoIn} = '0;
    altPinThreeIn = 1'b0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_prio();
    t_inputs();
    t_reloc();
    t_int();
    t_rerun();
    stop_test();
  end
endmodule : port_c_upper_pin_mux_tb_top
`default_nettype wire
